// ---- rtl/flow_pkg.sv ----
// Behaviour
// - Conditional jump with true condition loads PC with 16-bit target.
// - Conditional jump with false condition just steps PC to next instruction.
// - Carry clear/set test C; equal/not-equal test Z.
// - GE/LT use N xor V; GT/LE use Z or (N xor V).
// - Not-normalized/normalized use Z or (not U and not E).
// - Higher-or-same and lower aliases legal only with mode bit set.
// - Conditional jump reads flags but never changes them.
// - Conditional jump: two words, 6 cycles taken, 4 not taken.
// - Unconditional jump always loads 16-bit target, flags untouched.
// - Unconditional jump: 6 cycles plus extra fetch cycles, two words.
// - Call pushes PC then status at incremented SP, then jumps.
// - Call: 8 cycles plus extra fetch cycles, two words, flags untouched.
// - Address load writes computed address to destination, source unchanged.
// - Address load result usable by the very next instruction.
package flow_pkg;
  localparam int unsigned DATA_W = 16;
  localparam int unsigned ADDR_W = 4;
  localparam int unsigned CNT_W = 4;

  // ************************************************
  // Register indices
  // ************************************************
  localparam logic [3:0] REG_CMD = 4'h0;
  localparam logic [3:0] REG_STAT = 4'h1;
  localparam logic [3:0] REG_PC = 4'h2;
  localparam logic [3:0] REG_SP = 4'h3;
  localparam logic [3:0] REG_SR = 4'h4;
  localparam logic [3:0] REG_OMR = 4'h5;
  localparam logic [3:0] REG_EA_SRC = 4'h6;
  localparam logic [3:0] REG_EA_N = 4'h7;
  localparam logic [3:0] REG_EA_IMM = 4'h8;
  localparam logic [3:0] REG_EA_RES = 4'h9;

  // ************************************************
  // Field positions
  // ************************************************
  localparam int unsigned CMD_COND_LSB = 0;
  localparam int unsigned CMD_OP_LSB = 4;
  localparam int unsigned CMD_MODE_LSB = 8;
  localparam int unsigned STAT_BUSY = 0;
  localparam int unsigned STAT_ILLEGAL = 1;
  localparam int unsigned STAT_TAKEN = 2;
  localparam int unsigned SR_C = 0;
  localparam int unsigned SR_V = 1;
  localparam int unsigned SR_Z = 2;
  localparam int unsigned SR_N = 3;
  localparam int unsigned SR_U = 4;
  localparam int unsigned SR_E = 5;
  localparam int unsigned OMR_CC = 8;
  localparam int unsigned IMM6_W = 6;

  // ************************************************
  // Reset values and constants
  // ************************************************
  localparam logic [15:0] PC_RST = 16'h0000;
  localparam logic [15:0] SP_RST = 16'h0000;
  localparam logic [15:0] ZERO16 = 16'h0000;
  localparam logic [15:0] ONE16 = 16'h0001;
  localparam logic [15:0] TWO16 = 16'h0002;

  // ************************************************
  // Cycle counts
  // ************************************************
  localparam logic [3:0] CYC_JCC_TAKEN = 4'h6;
  localparam logic [3:0] CYC_JCC_NOT = 4'h4;
  localparam logic [3:0] CYC_JMP = 4'h6;
  localparam logic [3:0] CYC_JSR = 4'h8;
  localparam logic [3:0] CYC_EA_SHORT = 4'h2;
  localparam logic [3:0] CYC_EA_LONG = 4'h4;
  localparam logic [3:0] CYC_JX = 4'h0;
  localparam logic [3:0] CNT_FETCH = 4'h1;
  localparam logic [3:0] CNT_PUSH_PC = 4'h2;
  localparam logic [3:0] CNT_PUSH_SR = 4'h3;

  // ************************************************
  // Encodings
  // ************************************************
  typedef enum logic [2:0] {
    OP_JCC = 3'h0,
    OP_JMP = 3'h1,
    OP_JSR = 3'h2,
    OP_EA = 3'h3
  } op_t;

  typedef enum logic [3:0] {
    CC_CARRY_CLR = 4'h0,
    CC_CARRY_SET = 4'h1,
    CC_EQUAL = 4'h2,
    CC_SIGNED_GE = 4'h3,
    CC_SIGNED_GT = 4'h4,
    CC_SIGNED_LE = 4'h5,
    CC_SIGNED_LT = 4'h6,
    CC_NOT_EQUAL = 4'h7,
    CC_NOT_NORM = 4'h8,
    CC_NORM = 4'h9,
    CC_HIGHER_SAME = 4'ha,
    CC_LOWER = 4'hb
  } cond_t;

  typedef enum logic [2:0] {
    EA_POST_INC = 3'h0,
    EA_POST_DEC = 3'h1,
    EA_ADD_N = 3'h2,
    EA_ADD_IMM6 = 3'h3,
    EA_SUB_IMM6 = 3'h4,
    EA_ADD_IMM16 = 3'h5
  } ea_mode_t;
endpackage

// ---- rtl/cond_eval.sv ----
module cond_eval
  import flow_pkg::*;
(
  // Selection
  input wire logic [3:0] i_cond,
  input wire logic i_cc_mode,
  // Flags
  input wire logic [15:0] i_status,
  // Result
  output logic o_true,
  output logic o_legal
);
  wire logic c = i_status[SR_C];
  wire logic v = i_status[SR_V];
  wire logic z = i_status[SR_Z];
  wire logic n = i_status[SR_N];
  wire logic u = i_status[SR_U];
  wire logic e = i_status[SR_E];
  wire logic nv = n ^ v;
  wire logic znv = z | nv;
  wire logic norm = z | (~u & ~e);

  always_comb begin
    o_true = 1'b0;
    o_legal = 1'b1;
    case (i_cond)
      CC_CARRY_CLR: o_true = ~c;
      CC_CARRY_SET: o_true = c;
      CC_EQUAL: o_true = z;
      CC_NOT_EQUAL: o_true = ~z;
      CC_SIGNED_GE: o_true = ~nv;
      CC_SIGNED_LT: o_true = nv;
      CC_SIGNED_GT: o_true = ~znv;
      CC_SIGNED_LE: o_true = znv;
      CC_NOT_NORM: o_true = ~norm;
      CC_NORM: o_true = norm;
      CC_HIGHER_SAME: begin
        o_true = ~c;
        o_legal = i_cc_mode;
      end
      CC_LOWER: begin
        o_true = c;
        o_legal = i_cc_mode;
      end
      default: o_legal = 1'b0;
    endcase
  end
endmodule

// ---- rtl/jump_call_flow_unit.sv ----
// Decided for this implementation: the register addresses and strobed register access.
module jump_call_flow_unit
  import flow_pkg::*;
(
  // Clock and reset
  input wire logic i_mclk,
  input wire logic i_rst_b,
  // Register port
  input wire logic [flow_pkg::ADDR_W-1:0] i_addr,
  input wire logic [flow_pkg::DATA_W-1:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  output logic [flow_pkg::DATA_W-1:0] o_rdata,
  // Program memory
  output logic o_pm_rd,
  output logic [flow_pkg::DATA_W-1:0] o_pm_addr,
  input wire logic [flow_pkg::DATA_W-1:0] i_pm_data,
  // Data memory stack
  output logic o_dm_we,
  output logic [flow_pkg::DATA_W-1:0] o_dm_addr,
  output logic [flow_pkg::DATA_W-1:0] o_dm_wdata,
  // Status
  output logic o_busy
);
  import flow_pkg::*;

  typedef enum logic {
    ST_IDLE,
    ST_RUN
  } state_t;

  // ************************************************
  // Helpers
  // ************************************************
  function automatic logic [15:0] add16(input logic [15:0] a, input logic [15:0] b);
    logic [16:0] s;
    s = {1'b0, a} + {1'b0, b};
    return s[15:0];
  endfunction

  function automatic logic [15:0] sub16(input logic [15:0] a, input logic [15:0] b);
    logic [16:0] s;
    s = {1'b0, a} - {1'b0, b};
    return s[15:0];
  endfunction

  function automatic logic [3:0] add4(input logic [3:0] a, input logic [3:0] b);
    logic [4:0] s;
    s = {1'b0, a} + {1'b0, b};
    return s[3:0];
  endfunction

  function automatic logic [3:0] sub4(input logic [3:0] a);
    logic [4:0] s;
    s = {1'b0, a} - 5'h01;
    return s[3:0];
  endfunction

  // ************************************************
  // State
  // ************************************************
  state_t state_q;
  state_t state_d;
  logic busy_q;
  logic [3:0] cnt_q;
  logic [3:0] len_q;
  op_t op_q;
  logic [2:0] mode_q;
  logic take_q;
  logic [15:0] tgt_q;
  logic [15:0] pc_q;
  logic [15:0] sp_q;
  logic [15:0] sr_q;
  logic [15:0] omr_q;
  logic [15:0] ea_src_q;
  logic [15:0] ea_n_q;
  logic [5:0] ea_imm_q;
  logic [15:0] ea_res_q;
  logic illegal_q;
  logic taken_q;
  logic [15:0] rdata_q;
  logic pm_rd_q;
  logic [15:0] pm_addr_q;
  logic dm_we_q;
  logic [15:0] dm_addr_q;
  logic [15:0] dm_wdata_q;

  // ************************************************
  // Decode
  // ************************************************
  wire logic idle = (state_q == ST_IDLE);
  wire logic wr_cmd = i_wr && (i_addr == REG_CMD);
  wire logic wr_stat = i_wr && (i_addr == REG_STAT);
  wire logic wr_pc = i_wr && (i_addr == REG_PC) && idle;
  wire logic wr_sp = i_wr && (i_addr == REG_SP) && idle;
  wire logic wr_sr = i_wr && (i_addr == REG_SR) && idle;
  wire logic wr_omr = i_wr && (i_addr == REG_OMR);
  wire logic wr_src = i_wr && (i_addr == REG_EA_SRC) && idle;
  wire logic wr_n = i_wr && (i_addr == REG_EA_N) && idle;
  wire logic wr_imm = i_wr && (i_addr == REG_EA_IMM) && idle;

  wire logic [3:0] cmd_cond = i_wdata[CMD_COND_LSB +: 4];
  wire logic [2:0] cmd_op_raw = i_wdata[CMD_OP_LSB +: 3];
  wire logic [2:0] cmd_mode = i_wdata[CMD_MODE_LSB +: 3];
  wire logic cmd_is_jcc = (cmd_op_raw == OP_JCC);
  wire logic cmd_is_jmp = (cmd_op_raw == OP_JMP);
  wire logic cmd_is_jsr = (cmd_op_raw == OP_JSR);
  wire logic cmd_is_ea = (cmd_op_raw == OP_EA);
  wire logic ea_long_cmd = (cmd_mode == EA_ADD_IMM16);
  wire logic ea_mode_ok = (cmd_mode <= EA_ADD_IMM16);

  wire logic cond_true;
  wire logic cond_legal;

  // Flags are only read here, never written by any flow command
  cond_eval u_cond (
    .i_cond(cmd_cond),
    .i_cc_mode(omr_q[OMR_CC]),
    .i_status(sr_q),
    .o_true(cond_true),
    .o_legal(cond_legal)
  );

  wire logic cmd_legal = cmd_is_jmp || cmd_is_jsr || (cmd_is_jcc && cond_legal) ||
                         (cmd_is_ea && ea_mode_ok);
  wire logic start = wr_cmd && idle && cmd_legal;
  // A command written while busy or with a bad code is dropped and flagged
  wire logic refuse = wr_cmd && !(idle && cmd_legal);
  wire logic cmd_fetch = cmd_is_jcc || cmd_is_jmp || cmd_is_jsr ||
                         (cmd_is_ea && ea_long_cmd);

  wire logic [3:0] cmd_len =
    cmd_is_jsr ? add4(CYC_JSR, CYC_JX) :
    cmd_is_jmp ? add4(CYC_JMP, CYC_JX) :
    cmd_is_jcc ? (cond_true ? CYC_JCC_TAKEN : CYC_JCC_NOT) :
    (ea_long_cmd ? CYC_EA_LONG : CYC_EA_SHORT);

  wire logic last = (state_q == ST_RUN) && (cnt_q == sub4(len_q));

  // ************************************************
  // Address load arithmetic
  // ************************************************
  wire logic [15:0] imm6_ext = {10'h000, ea_imm_q};
  logic [15:0] ea_val;
  always_comb begin
    ea_val = ea_src_q;
    case (mode_q)
      EA_POST_INC: ea_val = add16(ea_src_q, ONE16);
      EA_POST_DEC: ea_val = sub16(ea_src_q, ONE16);
      EA_ADD_N: ea_val = add16(ea_src_q, ea_n_q);
      EA_ADD_IMM6: ea_val = add16(ea_src_q, imm6_ext);
      EA_SUB_IMM6: ea_val = sub16(ea_src_q, imm6_ext);
      EA_ADD_IMM16: ea_val = add16(ea_src_q, tgt_q);
      default: ea_val = ea_src_q;
    endcase
  end

  // ************************************************
  // Next program counter at the final cycle
  // ************************************************
  wire logic [15:0] pc_two = add16(pc_q, TWO16);
  wire logic [15:0] pc_one = add16(pc_q, ONE16);
  wire logic [15:0] sp_one = add16(sp_q, ONE16);
  wire logic [15:0] pc_fin =
    (op_q == OP_JMP) ? tgt_q :
    (op_q == OP_JSR) ? tgt_q :
    (op_q == OP_JCC) ? (take_q ? tgt_q : pc_two) :
    ((mode_q == EA_ADD_IMM16) ? pc_two : pc_one);
  wire logic push_pc = (state_q == ST_RUN) && (op_q == OP_JSR) && (cnt_q == CNT_PUSH_PC);
  wire logic push_sr = (state_q == ST_RUN) && (op_q == OP_JSR) && (cnt_q == CNT_PUSH_SR);

  // ************************************************
  // Sequencer
  // ************************************************
  always_comb begin
    state_d = state_q;
    case (state_q)
      ST_IDLE: if (start) begin
        state_d = ST_RUN;
      end
      ST_RUN: if (last) begin
        state_d = ST_IDLE;
      end
      default: state_d = ST_IDLE;
    endcase
  end

  always_ff @(posedge i_mclk) begin
    if (!i_rst_b) begin
      state_q <= ST_IDLE;
      busy_q <= 1'b0;
      cnt_q <= 4'h0;
      len_q <= 4'h0;
      op_q <= OP_JCC;
      mode_q <= 3'h0;
      take_q <= 1'b0;
    end else begin
      state_q <= state_d;
      // Registered copy so the pin carries no decode logic
      busy_q <= (state_d == ST_RUN);
      cnt_q <= (state_q == ST_RUN) ? add4(cnt_q, 4'h1) : 4'h0;
      if (start) begin
        len_q <= cmd_len;
        op_q <= op_t'(cmd_op_raw);
        mode_q <= cmd_mode;
        take_q <= cmd_is_jcc ? cond_true : 1'b1;
      end
    end
  end

  // Second program word arrives the cycle after the read strobe
  always_ff @(posedge i_mclk) begin
    if (!i_rst_b) begin
      tgt_q <= ZERO16;
    end else if ((state_q == ST_RUN) && (cnt_q == CNT_FETCH)) begin
      tgt_q <= i_pm_data;
    end
  end

  always_ff @(posedge i_mclk) begin
    if (!i_rst_b) begin
      pm_rd_q <= 1'b0;
      pm_addr_q <= ZERO16;
    end else begin
      pm_rd_q <= start && cmd_fetch;
      if (start && cmd_fetch) begin
        pm_addr_q <= pc_one;
      end
    end
  end

  // ************************************************
  // Stack pushes
  // ************************************************
  always_ff @(posedge i_mclk) begin
    if (!i_rst_b) begin
      dm_we_q <= 1'b0;
      dm_addr_q <= ZERO16;
      dm_wdata_q <= ZERO16;
    end else begin
      dm_we_q <= push_pc || push_sr;
      if (push_pc) begin
        dm_addr_q <= sp_one;
        dm_wdata_q <= pc_two;
      end else if (push_sr) begin
        dm_addr_q <= sp_one;
        dm_wdata_q <= sr_q;
      end
    end
  end

  // ************************************************
  // Architectural registers
  // ************************************************
  always_ff @(posedge i_mclk) begin
    if (!i_rst_b) begin
      pc_q <= PC_RST;
    end else if (last) begin
      pc_q <= pc_fin;
    end else if (wr_pc) begin
      pc_q <= i_wdata;
    end
  end

  always_ff @(posedge i_mclk) begin
    if (!i_rst_b) begin
      sp_q <= SP_RST;
    end else if (push_pc || push_sr) begin
      sp_q <= sp_one;
    end else if (wr_sp) begin
      sp_q <= i_wdata;
    end
  end

  // SR held while busy so flags cannot move under a running command; OMR writes land even while busy
  always_ff @(posedge i_mclk) begin
    if (!i_rst_b) begin
      sr_q <= ZERO16;
      omr_q <= ZERO16;
    end else begin
      if (wr_sr) begin
        sr_q <= i_wdata;
      end
      if (wr_omr) begin
        omr_q <= i_wdata;
      end
    end
  end

  always_ff @(posedge i_mclk) begin
    if (!i_rst_b) begin
      ea_src_q <= ZERO16;
      ea_n_q <= ZERO16;
      ea_imm_q <= 6'h00;
      ea_res_q <= ZERO16;
    end else begin
      if (wr_src) begin
        ea_src_q <= i_wdata;
      end
      if (wr_n) begin
        ea_n_q <= i_wdata;
      end
      if (wr_imm) begin
        ea_imm_q <= i_wdata[IMM6_W-1:0];
      end
      // Result lands with busy dropping, no extra slot before use
      if (last && (op_q == OP_EA)) begin
        ea_res_q <= ea_val;
      end
    end
  end

  // ************************************************
  // Status and read port
  // ************************************************
  always_ff @(posedge i_mclk) begin
    if (!i_rst_b) begin
      illegal_q <= 1'b0;
      taken_q <= 1'b0;
    end else begin
      // Set wins over a same-cycle write-one clear
      if (refuse) begin
        illegal_q <= 1'b1;
      end else if (wr_stat && i_wdata[STAT_ILLEGAL]) begin
        illegal_q <= 1'b0;
      end
      if (last) begin
        taken_q <= take_q && (op_q != OP_EA);
      end
    end
  end

  wire logic [15:0] stat_word = {13'h0000, taken_q, illegal_q, ~idle};
  wire logic [15:0] rd_mux =
    (i_addr == REG_STAT) ? stat_word :
    (i_addr == REG_PC) ? pc_q :
    (i_addr == REG_SP) ? sp_q :
    (i_addr == REG_SR) ? sr_q :
    (i_addr == REG_OMR) ? omr_q :
    (i_addr == REG_EA_SRC) ? ea_src_q :
    (i_addr == REG_EA_N) ? ea_n_q :
    (i_addr == REG_EA_IMM) ? imm6_ext :
    (i_addr == REG_EA_RES) ? ea_res_q : ZERO16;

  always_ff @(posedge i_mclk) begin
    if (!i_rst_b) begin
      rdata_q <= ZERO16;
    end else begin
      rdata_q <= i_rd ? rd_mux : ZERO16;
    end
  end

  assign o_rdata = rdata_q;
  assign o_pm_rd = pm_rd_q;
  assign o_pm_addr = pm_addr_q;
  assign o_dm_we = dm_we_q;
  assign o_dm_addr = dm_addr_q;
  assign o_dm_wdata = dm_wdata_q;
  assign o_busy = busy_q;
endmodule

// ---- sim/jcfu_props.sv ----
module jcfu_props
  import flow_pkg::*;
(
  // Clock and reset
  input wire logic i_mclk,
  input wire logic i_rst_b,
  // Register port
  input wire logic [flow_pkg::ADDR_W-1:0] i_addr,
  input wire logic [flow_pkg::DATA_W-1:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  input wire logic [flow_pkg::DATA_W-1:0] o_rdata,
  // Program memory and stack
  input wire logic o_pm_rd,
  input wire logic [flow_pkg::DATA_W-1:0] o_pm_addr,
  input wire logic [flow_pkg::DATA_W-1:0] i_pm_data,
  input wire logic o_dm_we,
  input wire logic [flow_pkg::DATA_W-1:0] o_dm_addr,
  input wire logic [flow_pkg::DATA_W-1:0] o_dm_wdata,
  // Status
  input wire logic o_busy
);
  timeunit 1ns;
  timeprecision 1ps;
  // ****************************************
  // Command decode
  // ****************************************
  wire cmd_w = i_wr && i_addr == REG_CMD && !o_busy;
  wire jcc_w = cmd_w && i_wdata[6:4] == OP_JCC && i_wdata[3:0] <= 4'h9;
  wire jmp_w = cmd_w && i_wdata[6:4] == OP_JMP && i_wdata[3:0] == 4'h0;
  wire jsr_w = cmd_w && i_wdata[6:4] == OP_JSR && i_wdata[3:0] == 4'h0;
  wire ea_w = cmd_w && i_wdata[6:4] == OP_EA && i_wdata[10:8] <= 3'h4;
  // Saturation not needed: any run past 8 already fails
  logic [3:0] busy_cnt_q;
  logic [3:0] busy_cnt_d;
  assign busy_cnt_d = o_busy ? busy_cnt_q + 4'h1 : 4'h0;
  always_ff @(posedge i_mclk) begin
    busy_cnt_q <= !i_rst_b ? 4'h0 : busy_cnt_d;
  end
  // ****************************************
  // Properties
  // ****************************************
  default clocking @(posedge i_mclk); endclocking
  default disable iff (!i_rst_b);
  sequence call_seq;
    jsr_w;
  endsequence
  sequence push_seq;
    o_pm_rd ##3 o_dm_we [*2] ##1 !o_dm_we;
  endsequence
  call_len_a: assert property (call_seq |=> o_busy [*8] ##1 !o_busy)
    else $error("call length wrong");
  call_push_a: assert property (call_seq |=> push_seq)
    else $error("call push timing wrong");
  push_order_a: assert property (
    o_dm_we && $past(o_dm_we) |-> o_dm_addr == $past(o_dm_addr) + 16'h0001)
    else $error("second push not one above first");
  jmp_len_a: assert property (jmp_w |=> o_busy [*6] ##1 !o_busy)
    else $error("jump length wrong");
  jcc_len_a: assert property (
    jcc_w |=> o_busy [*4] ##1 (!o_busy or (o_busy [*2] ##1 !o_busy)))
    else $error("conditional jump length wrong");
  ea_len_a: assert property (ea_w |=> o_busy [*2] ##1 !o_busy)
    else $error("address load length wrong");
  fetch_word_a: assert property ((jcc_w || jmp_w) |=> o_pm_rd ##1 !o_pm_rd)
    else $error("target word not fetched");
  jump_nopush_a: assert property ((jcc_w || jmp_w) |=> (!o_dm_we) [*6])
    else $error("jump wrote the stack");
  busy_cause_a: assert property ($rose(o_busy) |-> $past(cmd_w))
    else $error("busy without command");
  busy_bound_a: assert property (o_busy |-> busy_cnt_q < 4'h8)
    else $error("busy run too long");
endmodule

bind jump_call_flow_unit jcfu_props jcfu_props_inst (
  .i_mclk(i_mclk), .i_rst_b(i_rst_b), .i_addr(i_addr), .i_wdata(i_wdata),
  .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .o_pm_rd(o_pm_rd),
  .o_pm_addr(o_pm_addr), .i_pm_data(i_pm_data), .o_dm_we(o_dm_we),
  .o_dm_addr(o_dm_addr), .o_dm_wdata(o_dm_wdata), .o_busy(o_busy)
);

// ---- sim/flow_mem_model.sv ----
module flow_mem_model
  import flow_pkg::*;
(
  // Clock
  input wire logic i_mclk,
  // Program memory
  input wire logic i_pm_rd,
  input wire logic [flow_pkg::DATA_W-1:0] i_pm_addr,
  output logic [flow_pkg::DATA_W-1:0] o_pm_data,
  // Data memory stack
  input wire logic i_dm_we,
  input wire logic [flow_pkg::DATA_W-1:0] i_dm_addr,
  input wire logic [flow_pkg::DATA_W-1:0] i_dm_wdata
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [15:0] stk [0:255];
  int we_cnt = 0;
  initial o_pm_data = 16'h0000;
  // Word stands one cycle, then flips so a late sample never looks valid
  always @(posedge i_mclk) begin
    if (i_pm_rd) begin
      o_pm_data <= i_pm_addr ^ 16'ha5c3;
    end else begin
      o_pm_data <= ~o_pm_data;
    end
    if (i_dm_we) begin
      stk[i_dm_addr[7:0]] <= i_dm_wdata;
      we_cnt <= we_cnt + 1;
    end
  end
endmodule

// ---- sim/tb_jump_call_flow_unit.sv ----
module tb_jump_call_flow_unit;
  timeunit 1ns;
  timeprecision 1ps;
  import flow_pkg::*;
`define CHK(g, e) begin cmp_count++; if ((g) !== (e)) begin n_errors++; \
  $display("mismatch at %0t: got %h exp %h", $time, (g), (e)); end end
  logic i_mclk = 1'b0;
  logic i_rst_b = 1'b0;
  logic [3:0] i_addr = 4'h0;
  logic [15:0] i_wdata = 16'h0000;
  logic i_wr = 1'b0;
  logic i_rd = 1'b0;
  wire [15:0] o_rdata, o_pm_addr, pm_data, o_dm_addr, o_dm_wdata;
  wire o_pm_rd, o_dm_we, o_busy;
  int n_errors = 0;
  int cmp_count = 0;
  int cyc = 0;
  int n, k;
  logic tk = 1'b0;
  logic [15:0] p;
  logic [15:0] s;
  logic [15:0] sr_tab [7] = '{16'h0000, 16'h0001, 16'h0004, 16'h0008, 16'h000a,
    16'h0030, 16'h0002};
  logic [15:0] ea_tab [6] = '{16'hffff, 16'hfffd, 16'h0003, 16'h003d, 16'hffbf,
    16'hfffe + (16'h3001 ^ 16'ha5c3)};
  jump_call_flow_unit jump_call_flow_unit_inst (
    .i_mclk(i_mclk), .i_rst_b(i_rst_b), .i_addr(i_addr), .i_wdata(i_wdata),
    .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .o_pm_rd(o_pm_rd),
    .o_pm_addr(o_pm_addr), .i_pm_data(pm_data), .o_dm_we(o_dm_we),
    .o_dm_addr(o_dm_addr), .o_dm_wdata(o_dm_wdata), .o_busy(o_busy));
  flow_mem_model flow_mem_model_inst (
    .i_mclk(i_mclk), .i_pm_rd(o_pm_rd), .i_pm_addr(o_pm_addr), .o_pm_data(pm_data),
    .i_dm_we(o_dm_we), .i_dm_addr(o_dm_addr), .i_dm_wdata(o_dm_wdata));
  // ****************************************
  // Clock, watchdog and bus tasks
  // ****************************************
  always #5 i_mclk = ~i_mclk;
  always @(posedge i_mclk) begin
    cyc++;
    if (cyc == 20000) begin
      n_errors++;
      results();
    end
  end
  task automatic results;
    $display("comparisons %0d mismatches %0d", cmp_count, n_errors);
    if (n_errors == 0 && cmp_count > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge i_mclk);
    i_addr <= a;
    i_wdata <= d;
    i_wr <= 1'b1;
    @(posedge i_mclk);
    i_wr <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a, input logic [15:0] e);
    @(posedge i_mclk);
    i_addr <= a;
    i_rd <= 1'b1;
    @(posedge i_mclk);
    i_rd <= 1'b0;
    #1;
    `CHK(o_rdata, e)
  endtask
  // Counts busy cycles left; bounded so a stuck flag cannot hang
  task automatic settle(input int len);
    #1;
    n = 0;
    while (o_busy === 1'b1 && n < 20) begin
      n++;
      @(posedge i_mclk);
      #1;
    end
    `CHK(n, len)
  endtask
  task automatic run(input logic [15:0] cmd, input int len);
    wr(REG_CMD, cmd);
    settle(len);
  endtask
  function automatic logic ctrue(input logic [3:0] c, input logic [15:0] f);
    logic cf, vf, zf, nf, uf, ef;
    {ef, uf, nf, zf, vf, cf} = f[5:0];
    case (c)
      4'h0, 4'ha: return !cf;
      4'h1, 4'hb: return cf;
      4'h2: return zf;
      4'h3: return !(nf ^ vf);
      4'h4: return !(zf | (nf ^ vf));
      4'h5: return zf | (nf ^ vf);
      4'h6: return nf ^ vf;
      4'h7: return !zf;
      4'h8: return !(zf | (!uf & !ef));
      default: return zf | (!uf & !ef);
    endcase
  endfunction
  // ****************************************
  // Tests
  // ****************************************
  initial begin
    repeat (3) @(posedge i_mclk);
    i_rst_b <= 1'b1;
    rd(REG_PC, 16'h0000);
    rd(REG_SP, 16'h0000);
    wr(4'hc, 16'hffff);
    rd(4'hc, 16'h0000);
    // Every condition over flag patterns; aliases first without mode bit
    for (int m = 0; m < 2; m++) begin
      wr(REG_OMR, m ? 16'h0100 : 16'h0000);
      for (int c = 0; c < 12; c++) begin
        for (int j = 0; j < 7; j++) begin
          s = sr_tab[j];
          p = 16'h1000 + 16'(c * 16 + j);
          wr(REG_PC, p);
          wr(REG_SR, s);
          if (c >= 10 && m == 0) begin
            run({9'h000, OP_JCC, c[3:0]}, 0);
            rd(REG_STAT, {13'h0000, tk, 2'b10});
            wr(REG_STAT, 16'h0002);
            rd(REG_STAT, {13'h0000, tk, 2'b00});
            rd(REG_PC, p);
          end else begin
            tk = ctrue(c[3:0], s);
            run({9'h000, OP_JCC, c[3:0]}, tk ? 6 : 4);
            rd(REG_PC, tk ? (p + 16'h0001) ^ 16'ha5c3 : p + 16'h0002);
            rd(REG_SR, s);
            rd(REG_STAT, {13'h0000, tk, 2'b00});
          end
        end
      end
    end
    // Jump with a refused command and a PC write ignored mid-run
    for (int j = 0; j < 2; j++) begin
      wr(REG_PC, 16'h2000);
      wr(REG_SP, j ? 16'hfffe : 16'h0040);
      wr(REG_SR, 16'h0015);
      k = flow_mem_model_inst.we_cnt;
      wr(REG_CMD, {9'h000, OP_JMP, 4'h0});
      wr(REG_CMD, {9'h000, OP_JSR, 4'h0});
      wr(REG_PC, 16'h1234);
      settle(2);
      rd(REG_STAT, {13'h0000, 1'b1, 2'b10});
      wr(REG_STAT, 16'h0002);
      p = 16'h2001 ^ 16'ha5c3;
      rd(REG_PC, p);
      rd(REG_SR, 16'h0015);
      `CHK(flow_mem_model_inst.we_cnt, k)
      run({9'h000, OP_JSR, 4'h0}, 8);
      s = j ? 16'hfffe : 16'h0040;
      `CHK(flow_mem_model_inst.stk[8'(s + 16'h0001)], p + 16'h0002)
      `CHK(flow_mem_model_inst.stk[8'(s + 16'h0002)], 16'h0015)
      rd(REG_SP, s + 16'h0002);
      rd(REG_PC, (p + 16'h0001) ^ 16'ha5c3);
      rd(REG_SR, 16'h0015);
    end
    // Address load in every mode, result read at once
    wr(REG_EA_SRC, 16'hfffe);
    wr(REG_EA_N, 16'h0005);
    wr(REG_EA_IMM, 16'hffff);
    rd(REG_EA_IMM, 16'h003f);
    for (int m = 0; m < 6; m++) begin
      wr(REG_PC, 16'h3000);
      run({5'h00, 3'(m), 1'b0, OP_EA, 4'h0}, m == 5 ? 4 : 2);
      rd(REG_EA_RES, ea_tab[m]);
      rd(REG_EA_SRC, 16'hfffe);
      rd(REG_PC, m == 5 ? 16'h3002 : 16'h3001);
    end
    // Unknown address-load mode and unknown operation are both refused
    run({5'h00, 3'h6, 1'b0, OP_EA, 4'h0}, 0);
    rd(REG_STAT, {13'h0000, 1'b0, 2'b10});
    wr(REG_STAT, 16'h0002);
    run({9'h000, 3'h7, 4'h0}, 0);
    rd(REG_STAT, {13'h0000, 1'b0, 2'b10});
    rd(REG_PC, 16'h3002);
    results();
  end
endmodule
